// ---- fieldbus_mon_pkg.sv ----
`default_nettype none
package fieldbus_mon_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FB_TIMEOUT_MS = 630;
  localparam int unsigned FB_SHORT_MS = 25;
  localparam int unsigned RELAY_DELAY_MS = 1000;
  localparam int unsigned BLINK_STEP_MS = 100;
  localparam int unsigned BLINK_STEPS = 8;
  localparam int unsigned TIMER_W = 27;

  ////////////////////////////////////////////////////////////////////////
  // substitute process input words
  localparam logic [7:0] FAULT_CODE = 8'h5B;
  localparam int unsigned MALF_BIT = 5;
  localparam logic [15:0] MALF_MASK = 16'h0001 << MALF_BIT;
  localparam logic [15:0] FAULT_SW1 = {FAULT_CODE, 8'h00} | MALF_MASK;
  localparam logic [15:0] FAULT_CUR = 16'h0000;
  localparam logic [15:0] FAULT_SW2 = MALF_MASK;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] CTRL_RST = 8'h07;
  localparam int unsigned CTRL_PD_LO = 0;
  localparam int unsigned CTRL_TO_EN = 2;
  localparam int unsigned ST_SYS_FAULT = 0;
  localparam int unsigned ST_FB_EXPIRED = 1;
  localparam int unsigned ST_RELAY = 2;
  localparam int unsigned ST_DOUT_LO = 4;
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_SYS_FAULT = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [4:0] {
    PAT_OFF = 5'b00001,
    PAT_ON = 5'b00010,
    PAT_FLASH = 5'b00100,
    PAT_SINGLE = 5'b01000,
    PAT_DOUBLE = 5'b10000
  } pattern_e;

  typedef struct packed {
    logic [15:0] sw1;
    logic [15:0] cur;
    logic [15:0] sw2;
  } drive_words_s;

endpackage
`default_nettype wire

// ---- interval_timer.sv ----
`default_nettype none
module interval_timer #(
  parameter int unsigned W = fieldbus_mon_pkg::TIMER_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // control
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic [W-1:0] i_limit,
  // status
  output logic o_expired
);
  import fieldbus_mon_pkg::*;

  logic [W-1:0] cnt_r;
  logic exp_r;
  wire logic last_w = (cnt_r >= i_limit - W'(1));

  always_ff @(posedge i_clk) begin
    if (i_reset || (i_ce && i_clear)) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else if (i_ce && i_run && !exp_r) begin
      cnt_r <= cnt_r + W'(1);
      exp_r <= last_w;
    end
  end

  assign o_expired = exp_r;

  chk_clear_drops_expiry: assert property (@(posedge i_clk)
    disable iff (i_reset) (i_ce && i_clear) |=> !o_expired)
    else $error("timer still expired after clear");
  chk_expiry_after_limit: assert property (@(posedge i_clk)
    disable iff (i_reset) $rose(o_expired) |-> $past(last_w))
    else $error("timer expired before its limit");

endmodule // interval_timer
`default_nettype wire

// ---- blink_pattern.sv ----
`default_nettype none
module blink_pattern #(
  parameter int unsigned STEP_CYC =
    fieldbus_mon_pkg::BLINK_STEP_MS * fieldbus_mon_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // pattern select
  input wire fieldbus_mon_pkg::pattern_e i_mode,
  // indicator
  output logic o_led
);
  import fieldbus_mon_pkg::*;

  logic [31:0] tick_r;
  logic [2:0] phase_r;
  logic led_r;
  logic led_nxt;
  wire logic step_w = (tick_r >= STEP_CYC - 1);

  always_comb begin
    case (i_mode)
      PAT_ON: led_nxt = 1'b1;
      PAT_FLASH: led_nxt = phase_r[0];
      PAT_SINGLE: led_nxt = (phase_r == 3'd0);
      PAT_DOUBLE: led_nxt = (phase_r == 3'd0) || (phase_r == 3'd2);
      default: led_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick_r <= '0;
      phase_r <= '0;
      led_r <= 1'b0;
    end else if (i_ce) begin
      tick_r <= step_w ? '0 : tick_r + 32'd1;
      if (step_w) begin
        phase_r <= (phase_r == 3'(BLINK_STEPS - 1)) ? '0 : phase_r + 3'd1;
      end
      led_r <= led_nxt;
    end
  end

  assign o_led = led_r;

  chk_steady_mode: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce && (i_mode == PAT_ON || i_mode == PAT_OFF))
    |=> (o_led == $past(i_mode == PAT_ON)))
    else $error("steady pattern not shown");

endmodule // blink_pattern
`default_nettype wire

// ---- fieldbus_node_status_fault_monitor.sv ----
// Notes on behaviour
// - incoming-link LED on while incoming ring link intact, else off.
// - bus LED steady on in transfer, off when stopped, flashing otherwise.
// - outgoing-off LED lit only when outgoing segment cut by error.
// - parameter LED lit while parameter channel traffic runs.
// - fault LED off normally, single flash on drive-reported error.
// - fault LED double flash when drive output data not enabled.
// - fault LED steady on when drive link broken or maintenance off.
// - fault LED kept dark when no drive process words configured.
// - drive link fault reports code 91 in the status words.
// - drive link fault ignores control reset, clears when link returns.
// - fault substitutes 5B20, 0000, 0020 for the three input words.
// - both fault status words set bit 5; word one high byte code.
// - digital input byte keeps live inputs during drive link fault.
// - master stopping transmission starts 630 ms fieldbus timeout.
// - physical bus interruption uses about 25 ms timeout instead.
// - digital outputs reset at once when the timeout expires.
// - ready relay drops about one second after a timeout.
// - an extra io byte maps four inputs and two outputs; here o_io_byte carries only the four inputs, upper bits zero.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module fieldbus_node_status_fault_monitor #(
  parameter int unsigned FB_TIMEOUT_CYC =
    fieldbus_mon_pkg::FB_TIMEOUT_MS * fieldbus_mon_pkg::CYC_PER_MS,
  parameter int unsigned FB_SHORT_CYC =
    fieldbus_mon_pkg::FB_SHORT_MS * fieldbus_mon_pkg::CYC_PER_MS,
  parameter int unsigned RELAY_CYC =
    fieldbus_mon_pkg::RELAY_DELAY_MS * fieldbus_mon_pkg::CYC_PER_MS,
  parameter int unsigned BLINK_CYC =
    fieldbus_mon_pkg::BLINK_STEP_MS * fieldbus_mon_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // fieldbus status
  input wire logic i_incoming_link_ok,
  input wire logic i_bus_running,
  input wire logic i_bus_active,
  input wire logic i_cycle_done,
  input wire logic i_master_stopped,
  input wire logic i_phys_loss,
  input wire logic i_outgoing_off_err,
  input wire logic i_param_busy,
  // drive link status
  input wire logic i_drive_link_ok,
  input wire logic i_maint_off,
  input wire logic i_drive_err,
  input wire logic i_po_disabled,
  input wire fieldbus_mon_pkg::drive_words_s i_drive_words,
  // local io
  input wire logic [3:0] i_din,
  input wire logic [1:0] i_master_do,
  // axi4-lite slave
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // indicators
  output logic o_incoming_link_ok_led,
  output logic o_bus_active_led,
  output logic o_outgoing_off_led,
  output logic o_parameter_exchange_led,
  output logic o_fault_indicator_led,
  // process input data and outputs
  output fieldbus_mon_pkg::drive_words_s o_process_in,
  output logic [7:0] o_io_byte,
  output logic [1:0] o_dout,
  output logic o_ready_relay
);
  import fieldbus_mon_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] ctrl_r;
  logic [1:0] event_r;
  logic [1:0] event_nxt;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // supervision state
  logic rc_led_r;
  logic rd_led_r;
  logic tr_led_r;
  drive_words_s pin_r;
  logic [7:0] io_r;
  logic [1:0] dout_r;
  logic relay_r;
  logic fb_expired;
  logic relay_expired;
  logic fb_expired_d_r;
  logic sys_fault_d_r;

  ////////////////////////////////////////////////////////////////////////
  // decoding
  wire logic [1:0] pd_count = ctrl_r[CTRL_PD_LO +: 2];
  wire logic timeout_en = ctrl_r[CTRL_TO_EN];
  wire logic pd_zero = (pd_count == 2'd0);
  wire logic sys_fault = !pd_zero && (!i_drive_link_ok || i_maint_off);
  wire logic fb_run = i_master_stopped || i_phys_loss;
  wire logic fb_clear = i_cycle_done || !timeout_en;
  wire logic [TIMER_W-1:0] fb_limit = i_phys_loss ?
    TIMER_W'(FB_SHORT_CYC) : TIMER_W'(FB_TIMEOUT_CYC);
  wire logic timeout_rise = fb_expired && !fb_expired_d_r;
  wire logic fault_rise = sys_fault && !sys_fault_d_r;

  wire pattern_e ba_mode = i_bus_running ? PAT_ON :
    (i_bus_active ? PAT_FLASH : PAT_OFF);
  wire pattern_e fault_mode = pd_zero ? PAT_OFF :
    (sys_fault ? PAT_ON :
    (i_po_disabled ? PAT_DOUBLE :
    (i_drive_err ? PAT_SINGLE : PAT_OFF)));

  // fault words replace drive status; a zero ctrl pd count clears this
  wire drive_words_s fault_words = '{
    sw1: FAULT_SW1, cur: FAULT_CUR, sw2: FAULT_SW2};
  wire drive_words_s pin_nxt = sys_fault ? fault_words :
    i_drive_words;
  wire logic [7:0] io_nxt = {4'h0, i_din};
  wire logic [1:0] dout_nxt = fb_expired ? 2'b00 : i_master_do;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic aw_take = i_s_axi_awvalid && awready_r;
  wire logic w_take = i_s_axi_wvalid && wready_r;
  wire logic do_write = aw_held_r && w_held_r && !bvalid_r;
  wire logic ar_take = i_s_axi_arvalid && arready_r;
  wire logic wr_ctrl = do_write && (awaddr_r == ADDR_CTRL) && wstrb_r[0];
  wire logic wr_event = do_write && (awaddr_r == ADDR_EVENT) && wstrb_r[0];
  wire logic wr_known = (awaddr_r == ADDR_CTRL) ||
    (awaddr_r == ADDR_STATUS) || (awaddr_r == ADDR_EVENT);
  wire logic [1:0] ev_clear = wr_event ? wdata_r[1:0] : 2'b00;
  wire logic [1:0] ev_set = {fault_rise, timeout_rise};
  wire logic [31:0] status_word = {24'h00_0000, 2'b00, dout_r, 1'b0,
    relay_r, fb_expired, sys_fault};
  logic [31:0] rd_data;
  logic rd_ok;

  always_comb begin
    event_nxt = (event_r & ~ev_clear) | ev_set;
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (i_s_axi_araddr == ADDR_CTRL) begin
      rd_data = {24'h00_0000, ctrl_r};
    end else if (i_s_axi_araddr == ADDR_STATUS) begin
      rd_data = status_word;
    end else if (i_s_axi_araddr == ADDR_EVENT) begin
      rd_data = {30'h0000_0000, event_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi write channel
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (i_ce) begin
      if (aw_take) begin
        awaddr_r <= {i_s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      aw_held_r <= aw_take || (aw_held_r && !do_write);
      w_held_r <= w_take || (w_held_r && !do_write);
      awready_r <= !(aw_take || (aw_held_r && !do_write));
      wready_r <= !(w_take || (w_held_r && !do_write));
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read channel
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (i_ce) begin
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_data;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && i_s_axi_rready) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= CTRL_RST;
      event_r <= '0;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[7:0];
      end
      event_r <= event_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timeouts
  interval_timer #(.W(TIMER_W)) u_fb_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_clear(fb_clear),
    .i_run(fb_run),
    .i_limit(fb_limit),
    .o_expired(fb_expired)
  );

  interval_timer #(.W(TIMER_W)) u_relay_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_clear(!fb_expired),
    .i_run(1'b1),
    .i_limit(TIMER_W'(RELAY_CYC)),
    .o_expired(relay_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // indicators
  blink_pattern #(.STEP_CYC(BLINK_CYC)) u_ba_blink (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_mode(ba_mode),
    .o_led(o_bus_active_led)
  );

  blink_pattern #(.STEP_CYC(BLINK_CYC)) u_fault_blink (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_mode(fault_mode),
    .o_led(o_fault_indicator_led)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rc_led_r <= 1'b0;
      rd_led_r <= 1'b0;
      tr_led_r <= 1'b0;
      pin_r <= '0;
      io_r <= '0;
      dout_r <= '0;
      relay_r <= 1'b0;
      fb_expired_d_r <= 1'b0;
      sys_fault_d_r <= 1'b0;
    end else if (i_ce) begin
      rc_led_r <= i_incoming_link_ok;
      rd_led_r <= i_outgoing_off_err;
      tr_led_r <= i_param_busy;
      pin_r <= pin_nxt;
      io_r <= io_nxt;
      dout_r <= dout_nxt;
      relay_r <= !relay_expired;
      fb_expired_d_r <= fb_expired;
      sys_fault_d_r <= sys_fault;
    end
  end

  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready = wready_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_incoming_link_ok_led = rc_led_r;
  assign o_outgoing_off_led = rd_led_r;
  assign o_parameter_exchange_led = tr_led_r;
  assign o_process_in = pin_r;
  assign o_io_byte = io_r;
  assign o_dout = dout_r;
  assign o_ready_relay = relay_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_link_led_follow: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce) |=>
    o_incoming_link_ok_led == $past(i_incoming_link_ok))
    else $error("incoming link led wrong");
  chk_bus_led_run: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce && i_bus_running) |=> o_bus_active_led)
    else $error("bus led dark during transfer");
  chk_outgoing_led: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce) |=> o_outgoing_off_led == $past(i_outgoing_off_err))
    else $error("outgoing off led wrong");
  chk_param_led: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce) |=> o_parameter_exchange_led == $past(i_param_busy))
    else $error("parameter led wrong");
  chk_fault_led_on: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (i_ce && sys_fault) |=> o_fault_indicator_led)
    else $error("fault led dark on link fault");
  chk_fault_led_nopd: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (i_ce && pd_zero) |=> !o_fault_indicator_led)
    else $error("fault led lit without process words");
  chk_fault_words_sub: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (i_ce && sys_fault) |=> (o_process_in.sw1 == 16'h5B20 &&
    o_process_in.cur == 16'h0000 && o_process_in.sw2 == 16'h0020))
    else $error("fault words not substituted");
  chk_live_words: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce && !sys_fault) |=> o_process_in == $past(i_drive_words))
    else $error("drive words not passed through");
  chk_din_live: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce) |=> o_io_byte[3:0] == $past(i_din))
    else $error("digital inputs not refreshed");
  chk_dout_cleared: assert property (@(posedge i_clk)
    disable iff (i_reset) (i_ce && fb_expired) |=> o_dout == 2'b00)
    else $error("outputs kept after timeout");
  chk_dout_follow: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!i_reset && i_ce && !fb_expired) |=> o_dout == $past(i_master_do))
    else $error("outputs not following master");
  chk_relay_holds: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (i_ce && !fb_expired)[*2] |=> o_ready_relay)
    else $error("relay dropped without timeout");

endmodule // fieldbus_node_status_fault_monitor
`default_nettype wire

// ---- fieldbus_far_side_model.sv ----
`default_nettype none
module fieldbus_far_side_model
  import fieldbus_mon_pkg::*;
(
  // clock
  input wire logic i_clk,
  // bench controls
  input wire logic i_cyclic,
  input wire logic i_ctrl_run,
  input wire logic [1:0] i_do,
  // toward the node
  output logic o_cycle_done,
  output logic [1:0] o_master_do,
  output fieldbus_mon_pkg::drive_words_s o_drive_words
);
  logic [1:0] ph_r = 2'h0;
  logic [15:0] cnt_r = 16'h0000;
  always_ff @(posedge i_clk) begin
    ph_r <= ph_r + 2'h1;
    cnt_r <= cnt_r + 16'h0001;
  end
  // one exchange every four cycles while cyclic
  assign o_cycle_done = i_cyclic && (ph_r == 2'h0);
  // controller stop zeroes all output data
  assign o_master_do = i_ctrl_run ? i_do : 2'h0;
  // drive words change every cycle
  assign o_drive_words = {cnt_r, ~cnt_r, cnt_r ^ 16'h00ff};
endmodule // fieldbus_far_side_model
`default_nettype wire

// ---- fieldbus_node_status_fault_monitor_bench.sv ----
`default_nettype none
module fieldbus_node_status_fault_monitor_bench
  import fieldbus_mon_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TO_C = 40;
  localparam int SH_C = 10;
  localparam int RL_C = 30;
  localparam int BL_C = 4;
  logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1;
  logic i_incoming_link_ok = 1'b1, i_bus_running = 1'b1;
  logic i_bus_active = 1'b0, i_master_stopped = 1'b0, i_phys_loss = 1'b0;
  logic i_outgoing_off_err = 1'b0, i_param_busy = 1'b0;
  logic i_drive_link_ok = 1'b1, i_maint_off = 1'b0, i_drive_err = 1'b0;
  logic i_po_disabled = 1'b0, cyclic = 1'b1, ctrl_run = 1'b1;
  logic [3:0] i_din = 4'h0;
  logic [1:0] mdo_set = 2'h3;
  logic i_cycle_done;
  logic [1:0] i_master_do, o_dout;
  drive_words_s i_drive_words, o_process_in, w;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00, o_io_byte;
  logic [31:0] i_s_axi_wdata = 32'h0000_0000, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_bready = 1'b1, i_s_axi_rready = 1'b1;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_incoming_link_ok_led, o_bus_active_led;
  logic o_outgoing_off_led, o_parameter_exchange_led, o_fault_indicator_led;
  logic o_ready_relay;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  int fails = 0;
  int n_checks = 0;
  always #5 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////////
  fieldbus_far_side_model far_u (.i_clk, .i_cyclic(cyclic),
    .i_ctrl_run(ctrl_run), .i_do(mdo_set), .o_cycle_done(i_cycle_done),
    .o_master_do(i_master_do), .o_drive_words(i_drive_words));
  fieldbus_node_status_fault_monitor #(.FB_TIMEOUT_CYC(TO_C),
    .FB_SHORT_CYC(SH_C), .RELAY_CYC(RL_C), .BLINK_CYC(BL_C)) dut_u (
    .i_clk, .i_reset, .i_ce, .i_incoming_link_ok, .i_bus_running,
    .i_bus_active, .i_cycle_done, .i_master_stopped, .i_phys_loss,
    .i_outgoing_off_err, .i_param_busy, .i_drive_link_ok, .i_maint_off,
    .i_drive_err, .i_po_disabled, .i_drive_words, .i_din, .i_master_do,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
    .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready, .o_incoming_link_ok_led, .o_bus_active_led,
    .o_outgoing_off_led, .o_parameter_exchange_led, .o_fault_indicator_led,
    .o_process_in, .o_io_byte, .o_dout, .o_ready_relay);
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid === 1'b1) begin
        r = o_s_axi_bresp;
        break;
      end
    end
    if (n == 40) begin
      fails++;
      end_sim();
    end
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    d = 32'h0000_0000;
    r = 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid === 1'b1) begin
        d = o_s_axi_rdata;
        r = o_s_axi_rresp;
        break;
      end
    end
    if (n == 40) begin
      fails++;
      end_sim();
    end
    @(posedge i_clk);
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return o_dout === 2'h0;
      1: return o_ready_relay === 1'b0;
      2: return o_dout === 2'h3;
      default: return o_ready_relay === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int k, output int n);
    for (n = 0; n < 400 && !probe(k); n++) @(posedge i_clk);
    if (n == 400) begin
      fails++;
      end_sim();
    end
  endtask
  // lit cycles over one whole blink period
  task automatic ones(input int k, output int c);
    c = 0;
    repeat (8 * BL_C) begin
      @(posedge i_clk);
      c += (k == 0) ? int'(o_fault_indicator_led) : int'(o_bus_active_led);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic sc_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_CTRL, d, r);
    chk(d[7:0] === CTRL_RST && r === RESP_OKAY, "ctrl reset value");
    rd(8'h0c, d, r);
    chk(r === RESP_SLVERR && d === 32'h0000_0000, "unmapped read");
    wr(8'h0c, 32'h0000_0000, r);
    chk(r === RESP_SLVERR, "unmapped write");
    chk(o_ready_relay === 1'b1, "relay up after reset");
  endtask
  task automatic sc_leds();
    int c;
    i_outgoing_off_err <= 1'b1;
    i_param_busy <= 1'b1;
    tick(3);
    chk(o_incoming_link_ok_led & o_outgoing_off_led, "links on");
    chk(o_parameter_exchange_led & o_bus_active_led, "par bus on");
    i_ce <= 1'b0;
    i_param_busy <= 1'b0;
    tick(3);
    chk(o_parameter_exchange_led === 1'b1, "ce freezes led");
    i_ce <= 1'b1;
    i_incoming_link_ok <= 1'b0;
    i_outgoing_off_err <= 1'b0;
    i_param_busy <= 1'b0;
    i_bus_running <= 1'b0;
    tick(3);
    chk(o_incoming_link_ok_led === 1'b0, "in link off");
    chk(o_outgoing_off_led === 1'b0, "out off dark");
    chk(o_parameter_exchange_led === 1'b0, "param off");
    chk(o_bus_active_led === 1'b0, "bus off");
    i_bus_active <= 1'b1;
    tick(2);
    ones(1, c);
    chk(c == 4 * BL_C, "bus flash");
    i_bus_active <= 1'b0;
    i_bus_running <= 1'b1;
    i_incoming_link_ok <= 1'b1;
  endtask
  task automatic sc_fault();
    int c;
    logic [31:0] d;
    logic [1:0] r;
    i_drive_err <= 1'b1;
    tick(2);
    ones(0, c);
    chk(c == BL_C, "single flash");
    i_po_disabled <= 1'b1;
    tick(2);
    ones(0, c);
    chk(c == 2 * BL_C, "double flash");
    i_maint_off <= 1'b1;
    tick(2);
    ones(0, c);
    chk(c == 8 * BL_C, "maint steady");
    i_maint_off <= 1'b0;
    i_drive_err <= 1'b0;
    i_po_disabled <= 1'b0;
    i_drive_link_ok <= 1'b0;
    i_din <= 4'ha;
    tick(2);
    chk(o_process_in === 48'h5b20_0000_0020, "fault words");
    chk(o_io_byte === 8'h0a, "live inputs");
    i_din <= 4'h5;
    tick(2);
    chk(o_io_byte === 8'h05, "inputs refresh");
    ones(0, c);
    chk(c == 8 * BL_C, "link fault steady");
    rd(ADDR_STATUS, d, r);
    chk(d[ST_SYS_FAULT] === 1'b1, "status fault");
    wr(ADDR_CTRL, 32'h0000_0004, r);
    tick(2);
    ones(0, c);
    chk(c == 0, "io only dark");
    wr(ADDR_CTRL, 32'h0000_0007, r);
    i_drive_link_ok <= 1'b1;
    tick(3);
    w = i_drive_words;
    @(posedge i_clk);
    chk(o_process_in === w, "fault self clears");
    ones(0, c);
    chk(c == 0, "normal dark");
  endtask
  task automatic sc_timeout();
    int n;
    logic [31:0] d;
    logic [1:0] r;
    i_master_stopped <= 1'b1;
    tick(2 * TO_C);
    chk(o_dout === 2'h3, "exchange restarts");
    cyclic <= 1'b0;
    i_bus_running <= 1'b0;
    wait_for(0, n);
    chk(n >= TO_C - 2 && n <= TO_C + 4, "long timeout");
    rd(ADDR_STATUS, d, r);
    chk(d[ST_FB_EXPIRED] === 1'b1, "expiry flagged");
    wait_for(1, n);
    chk(n >= RL_C - 6 && n <= RL_C + 6, "relay drop");
    rd(ADDR_EVENT, d, r);
    chk(d[1:0] === 2'b11, "events latched");
    wr(ADDR_EVENT, 32'h0000_0003, r);
    rd(ADDR_EVENT, d, r);
    chk(d[1:0] === 2'b00 && r === RESP_OKAY, "events cleared");
    cyclic <= 1'b1;
    i_master_stopped <= 1'b0;
    i_bus_running <= 1'b1;
    wait_for(2, n);
    chk(n <= 10, "outputs resume");
    wait_for(3, n);
    chk(n <= 10, "relay back");
    cyclic <= 1'b0;
    i_phys_loss <= 1'b1;
    wait_for(0, n);
    chk(n >= SH_C - 2 && n <= SH_C + 4, "short timeout");
    cyclic <= 1'b1;
    i_phys_loss <= 1'b0;
    wait_for(2, n);
    ctrl_run <= 1'b0;
    tick(3);
    chk(o_dout === 2'h0, "master stop zeroes");
    ctrl_run <= 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    i_reset <= 1'b0;
    tick(2);
    sc_regs();
    sc_leds();
    sc_fault();
    sc_timeout();
    end_sim();
  end
endmodule // fieldbus_node_status_fault_monitor_bench
`default_nettype wire
